// ===== src/rths_top.v
`timescale 1ns/100ps
`include "rths_regs.vh"

// Overview of operation
// - Three-sensor: a limit hit reverses travel until that limit clears.
// - Three-sensor: a home rising edge at run speed stops and sets home.
// - Three-sensor with qualifier: finish on qualifier while home is on.
// - Other modes with qualifier: keep moving, finish on the qualifier.
// - Two-sensor: start in the set direction at the starting speed.
// - Two-sensor: a limit hit reverses and leaves it at the last speed.
// - Two-sensor: then the backward step count at starting speed sets home.
// - One-way: run speed in the set direction, decelerate as soon as home turns on.
// - One-way: leave home at last speed, then the step amount, set home.
// - One-way from outside home: losing home during the stop is an alarm.
// - Push: run to the stopper, reverse by the first backoff, and stop.
// - Push: approach again slowly, reverse by the push backoff, and stop.
// - Mode field 0 two-sensor, 1 three-sensor, 2 one-way, 3 push; reset 1.
// - Direction bit 0 negative, 1 positive; reset positive.
// - A push counts once torque limit holds for the set milliseconds.
// - Request only while ready; ready drops, move rises, done ends it.
module rths_top #(
    parameter MS_CYCLES = `RTHS_MS_NS / `RTHS_CLK_NS
) (
    input  wire                    I_CORE_CLK,
    input  wire                    I_RST_N,
    input  wire [`RTHS_ADDR_W-1:0] I_ADDR,
    input  wire [`RTHS_DATA_W-1:0] I_WDATA,
    input  wire                    I_WR,
    input  wire                    I_RD,
    output reg  [`RTHS_DATA_W-1:0] O_RDATA,
    input  wire                    I_HOMING_REQ,
    input  wire                    I_HOME_SENSOR,
    input  wire                    I_FWD_LIMIT,
    input  wire                    I_REV_LIMIT,
    input  wire                    I_QUAL_A,
    input  wire                    I_STEP_PHASE,
    input  wire                    I_ENC_ZERO,
    input  wire                    I_TORQUE_LIMIT,
    input  wire                    I_STEP,
    input  wire                    I_MOTOR_STOPPED,
    output reg                     O_RUN,
    output reg                     O_DIR,
    output reg  [1:0]              O_SPEED,
    output reg                     O_MOVE,
    output reg                     O_READY,
    output reg                     O_HOME_DONE,
    output reg                     O_ALARM,
    output reg                     O_IRQ
);

    localparam S_IDLE  = 3'h0;
    localparam S_SEEK  = 3'h1;
    localparam S_LEAVE = 3'h2;
    localparam S_STOP  = 3'h3;
    localparam S_STEPS = 3'h4;
    localparam S_QUAL  = 3'h5;
    localparam [`RTHS_DIV_W-1:0] MS_LAST = MS_CYCLES[`RTHS_DIV_W-1:0] - 1'b1;
    wire [`RTHS_IN_W-1:0]   in_lvl, in_rise;
    reg  [`RTHS_CTRL_W-1:0] ctrl_ff;
    reg  [`RTHS_MS_W-1:0]   push_ms_ff;
    reg  [`RTHS_STEP_W-1:0] back2_ff, oneway_ff, push1_ff, pushb_ff;
    reg  [`RTHS_IRQ_W-1:0]  irq_stat_ff, irq_mask_ff;
    reg  [2:0]              state_ff, nxt_state, after_ff, nxt_after;
    reg  [1:0]              mode_ff, nxt_mode, nxt_speed;
    reg  [`RTHS_STEP_W-1:0] steps_ff, nxt_steps;
    reg  [`RTHS_DIV_W-1:0]  ms_div_ff, nxt_ms_div;
    reg  [`RTHS_MS_W-1:0]   ms_cnt_ff, nxt_ms_cnt;
    reg                     pass_ff, nxt_pass, outside_ff, nxt_outside;
    reg                     nxt_run, nxt_dir, nxt_move, nxt_ready, nxt_done;
    reg                     nxt_alarm, qual_prev_ff;
    wire                    home_lvl, lim_any, push_hit;
    wire                    qual_on, qual_lvl, qual_rise;
    wire [`RTHS_IRQ_W-1:0]  irq_ev, irq_clr, nxt_irq_stat;

    // One synchroniser bank for the sensor, qualifier, torque and request inputs; I_STEP and I_MOTOR_STOPPED are used unsynchronised
    rths_sync #(
        .WIDTH (`RTHS_IN_W)
    ) u_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_async ({I_HOMING_REQ, I_TORQUE_LIMIT, I_ENC_ZERO, I_STEP_PHASE,
                   I_QUAL_A, I_REV_LIMIT, I_FWD_LIMIT, I_HOME_SENSOR}),
        .o_level (in_lvl),
        .o_rise  (in_rise)
    );

    assign home_lvl = in_lvl[`RTHS_IN_HOME];
    assign lim_any  = in_lvl[`RTHS_IN_FWD] | in_lvl[`RTHS_IN_REV];

    // Qualifier: all enabled sources must be on together
    assign qual_on  = ctrl_ff[`RTHS_CTRL_QUALIFIER_INPUT_A] |
                      (ctrl_ff[`RTHS_CTRL_TZ] != `RTHS_TZ_NONE);
    assign qual_lvl = qual_on &
        (~ctrl_ff[`RTHS_CTRL_QUALIFIER_INPUT_A] | in_lvl[`RTHS_IN_QUAL]) &
        ((ctrl_ff[`RTHS_CTRL_TZ] != `RTHS_TZ_PHASE) | in_lvl[`RTHS_IN_PHASE]) &
        ((ctrl_ff[`RTHS_CTRL_TZ] != `RTHS_TZ_ZERO) | in_lvl[`RTHS_IN_ZERO]);
    assign qual_rise = qual_lvl & ~qual_prev_ff;

    // Push judged after torque limit held the programmed time
    assign push_hit = in_lvl[`RTHS_IN_TORQUE] &&
                      (ms_cnt_ff >= push_ms_ff);

    // Sequencer next state
    always @* begin
        nxt_state   = state_ff;
        nxt_after   = after_ff;
        nxt_mode    = mode_ff;
        nxt_speed   = O_SPEED;
        nxt_steps   = steps_ff;
        nxt_pass    = pass_ff;
        nxt_outside = outside_ff;
        nxt_run     = O_RUN;
        nxt_dir     = O_DIR;
        nxt_move    = O_MOVE;
        nxt_ready   = O_READY;
        nxt_done    = O_HOME_DONE;
        nxt_alarm   = O_ALARM;
        nxt_ms_div  = {`RTHS_DIV_W{1'b0}};
        nxt_ms_cnt  = {`RTHS_MS_W{1'b0}};
        case (state_ff)
            S_IDLE: begin
                // Requests outside ready are ignored
                if (in_rise[`RTHS_IN_REQ] && O_READY) begin
                    nxt_mode    = ctrl_ff[`RTHS_CTRL_MODE];
                    nxt_dir     = ctrl_ff[`RTHS_CTRL_DIR];
                    nxt_ready   = 1'b0;
                    nxt_move    = 1'b1;
                    nxt_done    = 1'b0;
                    nxt_alarm   = 1'b0;
                    nxt_pass    = 1'b0;
                    nxt_outside = ~home_lvl;
                    nxt_run     = 1'b1;
                    nxt_speed   = (ctrl_ff[`RTHS_CTRL_MODE] ==
                                   `RTHS_MODE_TWO) ?
                                  `RTHS_SPD_START : `RTHS_SPD_RUN;
                    nxt_state   = S_SEEK;
                end
            end
            S_SEEK: begin
                case (mode_ff)
                    `RTHS_MODE_THREE: begin
                        if (lim_any) begin
                            nxt_dir   = ~O_DIR;
                            nxt_speed = `RTHS_SPD_LAST;
                            nxt_state = S_LEAVE;
                        end else if (in_rise[`RTHS_IN_HOME]) begin
                            if (qual_on) begin
                                nxt_speed = `RTHS_SPD_LAST;
                                nxt_state = S_QUAL;
                            end else begin
                                nxt_run   = 1'b0;
                                nxt_after = S_IDLE;
                                nxt_state = S_STOP;
                            end
                        end
                    end
                    `RTHS_MODE_TWO: begin
                        if (lim_any) begin
                            nxt_dir   = ~O_DIR;
                            nxt_speed = `RTHS_SPD_LAST;
                            nxt_state = S_LEAVE;
                        end
                    end
                    `RTHS_MODE_ONEWAY: begin
                        if (in_rise[`RTHS_IN_HOME]) begin
                            nxt_run   = 1'b0;
                            nxt_after = S_LEAVE;
                            nxt_state = S_STOP;
                        end
                    end
                    default: begin
                        // Torque timer: divider to ms, then ms count
                        if (in_lvl[`RTHS_IN_TORQUE]) begin
                            nxt_ms_cnt = ms_cnt_ff;
                            if (ms_div_ff == MS_LAST) begin
                                if (!push_hit)
                                    nxt_ms_cnt = ms_cnt_ff + 1'b1;
                            end else begin
                                nxt_ms_div = ms_div_ff + 1'b1;
                            end
                        end
                        if (push_hit) begin
                            nxt_dir   = ~O_DIR;
                            nxt_speed = `RTHS_SPD_START;
                            nxt_steps = pass_ff ? pushb_ff : push1_ff;
                            nxt_state = S_STEPS;
                        end
                    end
                endcase
            end
            S_LEAVE: begin
                if (mode_ff == `RTHS_MODE_ONEWAY ? !home_lvl : !lim_any) begin
                    if (mode_ff == `RTHS_MODE_THREE) begin
                        nxt_speed = `RTHS_SPD_RUN;
                        nxt_state = S_SEEK;
                    end else begin
                        nxt_speed = `RTHS_SPD_START;
                        nxt_steps = (mode_ff == `RTHS_MODE_TWO) ?
                                    back2_ff : oneway_ff;
                        nxt_state = S_STEPS;
                    end
                end
            end
            S_STOP: begin
                if (mode_ff == `RTHS_MODE_ONEWAY && after_ff == S_LEAVE &&
                    outside_ff && !home_lvl) begin
                    nxt_alarm = 1'b1;
                    nxt_move  = 1'b0;
                    nxt_ready = 1'b1;
                    nxt_state = S_IDLE;
                end else if (I_MOTOR_STOPPED) begin
                    case (after_ff)
                        S_LEAVE: begin
                            nxt_run   = 1'b1;
                            nxt_speed = `RTHS_SPD_LAST;
                            nxt_state = S_LEAVE;
                        end
                        S_SEEK: begin
                            nxt_run   = 1'b1;
                            nxt_dir   = ~O_DIR;
                            nxt_speed = `RTHS_SPD_START;
                            nxt_pass  = 1'b1;
                            nxt_state = S_SEEK;
                        end
                        default: begin
                            nxt_done  = 1'b1;
                            nxt_ready = 1'b1;
                            nxt_move  = 1'b0;
                            nxt_state = S_IDLE;
                        end
                    endcase
                end
            end
            S_STEPS: begin
                if (steps_ff == {`RTHS_STEP_W{1'b0}}) begin
                    if (mode_ff == `RTHS_MODE_PUSH && !pass_ff) begin
                        nxt_run   = 1'b0;
                        nxt_after = S_SEEK;
                        nxt_state = S_STOP;
                    end else if (qual_on) begin
                        nxt_speed = `RTHS_SPD_LAST;
                        nxt_state = S_QUAL;
                    end else begin
                        nxt_run   = 1'b0;
                        nxt_after = S_IDLE;
                        nxt_state = S_STOP;
                    end
                end else if (I_STEP) begin
                    nxt_steps = steps_ff - 1'b1;
                end
            end
            S_QUAL: begin
                // Three-sensor also needs home still on
                if (qual_rise && (mode_ff != `RTHS_MODE_THREE ||
                                  home_lvl)) begin
                    nxt_run   = 1'b0;
                    nxt_after = S_IDLE;
                    nxt_state = S_STOP;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // Sequencer and motor command registers
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_ff     <= S_IDLE;
            after_ff     <= S_IDLE;
            mode_ff      <= `RTHS_MODE_THREE;
            steps_ff     <= {`RTHS_STEP_W{1'b0}};
            ms_div_ff    <= {`RTHS_DIV_W{1'b0}};
            ms_cnt_ff    <= {`RTHS_MS_W{1'b0}};
            pass_ff      <= 1'b0;
            outside_ff   <= 1'b0;
            qual_prev_ff <= 1'b0;
            O_RUN        <= 1'b0;
            O_DIR        <= 1'b0;
            O_SPEED      <= `RTHS_SPD_START;
            O_MOVE       <= 1'b0;
            O_READY      <= 1'b1;
            O_HOME_DONE  <= 1'b0;
            O_ALARM      <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            after_ff     <= nxt_after;
            mode_ff      <= nxt_mode;
            steps_ff     <= nxt_steps;
            ms_div_ff    <= nxt_ms_div;
            ms_cnt_ff    <= nxt_ms_cnt;
            pass_ff      <= nxt_pass;
            outside_ff   <= nxt_outside;
            qual_prev_ff <= qual_lvl;
            O_RUN        <= nxt_run;
            O_DIR        <= nxt_dir;
            O_SPEED      <= nxt_speed;
            O_MOVE       <= nxt_move;
            O_READY      <= nxt_ready;
            O_HOME_DONE  <= nxt_done;
            O_ALARM      <= nxt_alarm;
        end
    end

    // Events; a new event wins over a clearing read
    assign irq_ev[`RTHS_IRQ_DONE]  = nxt_done & ~O_HOME_DONE;
    assign irq_ev[`RTHS_IRQ_ALARM] = nxt_alarm & ~O_ALARM;
    assign irq_clr = (I_RD && I_ADDR == `RTHS_OFS_IRQ_STAT) ?
                     {`RTHS_IRQ_W{1'b1}} : {`RTHS_IRQ_W{1'b0}};
    assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

    // Register writes, status and interrupt line
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_ff     <= `RTHS_CTRL_RST;
            push_ms_ff  <= `RTHS_PUSH_TIME_RST;
            back2_ff    <= `RTHS_BACK2_RST;
            oneway_ff   <= `RTHS_ONEWAY_RST;
            push1_ff    <= `RTHS_PUSH_1ST_RST;
            pushb_ff    <= `RTHS_PUSH_BACK_RST;
            irq_stat_ff <= {`RTHS_IRQ_W{1'b0}};
            irq_mask_ff <= {`RTHS_IRQ_W{1'b0}};
            O_IRQ       <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            O_IRQ       <= |(nxt_irq_stat & irq_mask_ff);
            if (I_WR) begin
                case (I_ADDR)
                    `RTHS_OFS_CTRL: ctrl_ff <= I_WDATA[`RTHS_CTRL_W-1:0];
                    `RTHS_OFS_PUSH_TIME: push_ms_ff <= I_WDATA[`RTHS_MS_W-1:0];
                    `RTHS_OFS_BACK2: back2_ff <= I_WDATA[`RTHS_STEP_W-1:0];
                    `RTHS_OFS_ONEWAY: oneway_ff <= I_WDATA[`RTHS_STEP_W-1:0];
                    `RTHS_OFS_PUSH_1ST: push1_ff <= I_WDATA[`RTHS_STEP_W-1:0];
                    `RTHS_OFS_PUSH_BACK: pushb_ff <= I_WDATA[`RTHS_STEP_W-1:0];
                    `RTHS_OFS_IRQ_MASK: irq_mask_ff <= I_WDATA[`RTHS_IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= {`RTHS_DATA_W{1'b0}};
        end else if (!I_RD) begin
            O_RDATA <= {`RTHS_DATA_W{1'b0}};
        end else begin
            case (I_ADDR)
                `RTHS_OFS_CTRL:      O_RDATA <= {26'h0, ctrl_ff};
                `RTHS_OFS_PUSH_TIME: O_RDATA <= {16'h0, push_ms_ff};
                `RTHS_OFS_BACK2:     O_RDATA <= {9'h0, back2_ff};
                `RTHS_OFS_ONEWAY:    O_RDATA <= {9'h0, oneway_ff};
                `RTHS_OFS_PUSH_1ST:  O_RDATA <= {9'h0, push1_ff};
                `RTHS_OFS_PUSH_BACK: O_RDATA <= {9'h0, pushb_ff};
                `RTHS_OFS_STATUS:
                    O_RDATA <= {20'h0, state_ff, mode_ff, pass_ff,
                                O_DIR, O_RUN, O_MOVE, O_READY,
                                O_HOME_DONE, O_ALARM};
                `RTHS_OFS_IRQ_STAT:  O_RDATA <= {30'h0, irq_stat_ff};
                `RTHS_OFS_IRQ_MASK:  O_RDATA <= {30'h0, irq_mask_ff};
                default:             O_RDATA <= {`RTHS_DATA_W{1'b0}};
            endcase
        end
    end

endmodule // rths_top

// ===== src/rths_regs.vh
`ifndef RTHS_REGS_VH
`define RTHS_REGS_VH

// Register bus shape
`define RTHS_ADDR_W        8
`define RTHS_DATA_W        32
`define RTHS_STEP_W        23
`define RTHS_MS_W          16

// Register byte offsets
`define RTHS_OFS_CTRL      8'h00
`define RTHS_OFS_PUSH_TIME 8'h04
`define RTHS_OFS_BACK2     8'h08
`define RTHS_OFS_ONEWAY    8'h0c
`define RTHS_OFS_PUSH_1ST  8'h10
`define RTHS_OFS_PUSH_BACK 8'h14
`define RTHS_OFS_STATUS    8'h18
`define RTHS_OFS_IRQ_STAT  8'h1c
`define RTHS_OFS_IRQ_MASK  8'h20

// Control register fields
`define RTHS_CTRL_W        6
`define RTHS_CTRL_MODE     1:0
`define RTHS_CTRL_DIR      2
`define RTHS_CTRL_QUALIFIER_INPUT_A     3
`define RTHS_CTRL_TZ       5:4

// Reset values
`define RTHS_CTRL_RST      6'h05
`define RTHS_PUSH_TIME_RST 16'h00c8
`define RTHS_BACK2_RST     23'h0001f4
`define RTHS_ONEWAY_RST    23'h0001f4
`define RTHS_PUSH_1ST_RST  23'h000000
`define RTHS_PUSH_BACK_RST 23'h0001f4

// Homing modes
`define RTHS_MODE_TWO      2'h0
`define RTHS_MODE_THREE    2'h1
`define RTHS_MODE_ONEWAY   2'h2
`define RTHS_MODE_PUSH     2'h3

// Qualifier pulse selection
`define RTHS_TZ_NONE       2'h0
`define RTHS_TZ_PHASE      2'h1
`define RTHS_TZ_ZERO       2'h2

// Speed profile selection toward the profile generator
`define RTHS_SPD_START     2'h1
`define RTHS_SPD_RUN       2'h2
`define RTHS_SPD_LAST      2'h3

// Interrupt status bits
`define RTHS_IRQ_W         2
`define RTHS_IRQ_DONE      0
`define RTHS_IRQ_ALARM     1

// Synchronised input vector positions
`define RTHS_IN_W          8
`define RTHS_IN_HOME       0
`define RTHS_IN_FWD        1
`define RTHS_IN_REV        2
`define RTHS_IN_QUAL       3
`define RTHS_IN_PHASE      4
`define RTHS_IN_ZERO       5
`define RTHS_IN_TORQUE     6
`define RTHS_IN_REQ        7

// Timing
`define RTHS_CLK_NS        5
`define RTHS_MS_NS         1000000
`define RTHS_DIV_W         24

`endif

// ===== src/rths_sync.v
`timescale 1ns/100ps
`include "rths_regs.vh"

module rths_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_level,
    output reg  [WIDTH-1:0] o_rise
);

    reg  [WIDTH-1:0] meta_ff;
    reg  [WIDTH-1:0] sync_ff;
    reg  [WIDTH-1:0] hold_ff;
    wire [WIDTH-1:0] agree;

    // A change counts only once the second and third stages agree
    assign agree = ~(sync_ff ^ hold_ff);

    // Three stages; the first is read by the second only
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
            hold_ff <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
            o_rise  <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            hold_ff <= sync_ff;
            o_level <= (agree & hold_ff) | (~agree & o_level);
            o_rise  <= agree & hold_ff & ~o_level;
        end
    end

endmodule // rths_sync

// ===== bench/rths_props.sv
`timescale 1ns/100ps
module rths_props (
    input wire        I_CORE_CLK,
    input wire        I_RST_N,
    input wire        I_RD,
    input wire        I_MOTOR_STOPPED,
    input wire [31:0] O_RDATA,
    input wire        O_RUN,
    input wire [1:0]  O_SPEED,
    input wire        O_MOVE,
    input wire        O_READY,
    input wire        O_HOME_DONE,
    input wire        O_ALARM
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    // Idle, busy and the two endings never overlap
    a_idle_busy: assert property (!(O_READY && O_MOVE))
        else $error("ready and move together");
    a_run_in_move: assert property (O_RUN |-> O_MOVE)
        else $error("run outside homing");
    a_start_state: assert property ($fell(O_READY) |->
        O_MOVE && O_RUN && !O_HOME_DONE && !O_ALARM) else $error("bad start");
    a_done_end: assert property ($rose(O_HOME_DONE) |->
        $fell(O_MOVE) && O_READY && $past(I_MOTOR_STOPPED))
        else $error("done without a stopped motor");
    a_alarm_end: assert property ($rose(O_ALARM) |->
        $fell(O_MOVE) && O_READY && !O_RUN) else $error("bad alarm end");
    a_done_xor_alarm: assert property (!(O_HOME_DONE && O_ALARM))
        else $error("done and alarm together");
    a_speed_code: assert property (O_SPEED != 2'h0)
        else $error("speed code zero");
    // Read data may only stand in the cycle after a read strobe
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data outside read slot");
endmodule // rths_props

bind rths_top rths_props props_u (.I_CORE_CLK(I_CORE_CLK),
    .I_RST_N(I_RST_N), .I_RD(I_RD), .I_MOTOR_STOPPED(I_MOTOR_STOPPED),
    .O_RDATA(O_RDATA), .O_RUN(O_RUN), .O_SPEED(O_SPEED), .O_MOVE(O_MOVE),
    .O_READY(O_READY), .O_HOME_DONE(O_HOME_DONE), .O_ALARM(O_ALARM));

// ===== bench/rths_motor.sv
`timescale 1ns/100ps
module rths_motor (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire       i_run,
    input  wire       i_dir,
    input  wire       i_coast,
    output wire       o_step,
    output reg        o_stopped,
    output reg  [7:0] o_pos,
    output wire       o_home,
    output wire       o_fwd,
    output wire       o_torque,
    output wire       o_qual
);
    reg [3:0] div_ff;
    reg [7:0] dec_ff;
    // Fixed sensor spots; the stopper sits on the forward limit
    assign o_home   = o_pos >= 8'h14 && o_pos <= 8'h18;
    assign o_fwd    = o_pos >= 8'h28;
    assign o_torque = o_fwd && i_dir && i_run;
    assign o_qual   = o_pos == 8'h16;
    // A coasting load keeps stepping while it stops, to force overrun
    assign o_step   = div_ff == 4'hf &&
                      (i_run || (i_coast && dec_ff != 8'h0));
    // One step per 16 clocks, so sensor delay never costs a step
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_ff    <= 4'h0;
            dec_ff    <= 8'h00;
            o_stopped <= 1'b1;
            o_pos     <= 8'h05;
        end else begin
            div_ff <= div_ff + 4'h1;
            if (o_step && !(i_dir && o_pos == 8'h28))
                o_pos <= i_dir ? o_pos + 8'h1 : o_pos - 8'h1;
            if (i_run) begin
                o_stopped <= 1'b0;
                dec_ff    <= i_coast ? 8'hff : 8'h18;
            end else if (dec_ff != 8'h00)
                dec_ff <= dec_ff - 8'h01;
            else
                o_stopped <= 1'b1;
        end
    end
endmodule // rths_motor

// ===== bench/return_to_home_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "rths_regs.vh"
module return_to_home_sequencer_tb_top;
    reg        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    reg        req = 1'b0, coast = 1'b0;
    reg [7:0]  addr = 8'h00;
    reg [31:0] wdata = 32'h0;
    integer    fail_count = 0, n_compared = 0, n;
    wire       run, dir, move, ready, done, alarm, irq, step, stop;
    wire       home, fwd, trq, qual;
    wire [1:0] spd;
    wire [7:0] pos;
    wire [31:0] rdata;
    // Core clock
    always #2.5 clk = ~clk;
    rths_top #(.MS_CYCLES(10)) dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_HOMING_REQ(req), .I_HOME_SENSOR(home), .I_FWD_LIMIT(fwd),
        .I_REV_LIMIT(1'b0), .I_QUAL_A(qual), .I_STEP_PHASE(1'b0),
        .I_ENC_ZERO(qual), .I_TORQUE_LIMIT(trq), .I_STEP(step),
        .I_MOTOR_STOPPED(stop), .O_RUN(run), .O_DIR(dir), .O_SPEED(spd),
        .O_MOVE(move), .O_READY(ready), .O_HOME_DONE(done), .O_ALARM(alarm),
        .O_IRQ(irq));
    rths_motor mot_u (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_dir(dir),
        .i_coast(coast), .o_step(step), .o_stopped(stop), .o_pos(pos),
        .o_home(home), .o_fwd(fwd), .o_torque(trq), .o_qual(qual));
    // Compare and count
    task chk(input string nm, input [31:0] s, input [31:0] e);
        n_compared = n_compared + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    // One-cycle strobe; read data is only looked at in the next cycle
    task bus(input w, input [7:0] a, input [31:0] d);
        @(posedge clk) wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk) wr <= 1'b0;
        rd <= 1'b0;
        if (!w) @(negedge clk) chk("rdata", rdata, d);
    endtask
    // Request from idle, check the opening speed, wait for the finish
    task homing(input [1:0] s0, input [7:0] e, input al);
        wait (stop === 1'b1);
        @(posedge clk) req <= 1'b1;
        n = 0;
        while (ready === 1'b1 && n < 40) begin
            @(negedge clk);
            n = n + 1;
        end
        chk("speed", {30'h0, spd}, {30'h0, s0});
        chk("move", {31'h0, move}, 32'h1);
        @(posedge clk) req <= 1'b0;
        while (ready !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n = n + 1;
        end
        chk("pos", {24'h0, pos}, {24'h0, e});
        chk("alarm", {31'h0, alarm}, {31'h0, al});
        chk("done", {31'h0, done}, {31'h0, !al});
        chk("move", {31'h0, move}, 32'h0);
    endtask
    // Each run starts where the previous one stopped
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `RTHS_OFS_CTRL, 32'h5);
        bus(1'b0, 8'h40, 32'h0);
        bus(1'b1, `RTHS_OFS_IRQ_MASK, 32'h3);
        homing(2'h2, 8'h14, 1'b0);
        @(negedge clk) chk("irq", {31'h0, irq}, 32'h1);
        bus(1'b0, `RTHS_OFS_IRQ_STAT, 32'h1);
        @(negedge clk) chk("irq", {31'h0, irq}, 32'h0);
        homing(2'h2, 8'h18, 1'b0);
        bus(1'b1, `RTHS_OFS_CTRL, 32'hd);
        homing(2'h2, 8'h16, 1'b0);
        bus(1'b1, `RTHS_OFS_BACK2, 32'h5);
        bus(1'b1, `RTHS_OFS_CTRL, 32'h4);
        homing(2'h1, 8'h22, 1'b0);
        bus(1'b1, `RTHS_OFS_ONEWAY, 32'h3);
        bus(1'b1, `RTHS_OFS_CTRL, 32'h2);
        homing(2'h2, 8'h10, 1'b0);
        bus(1'b1, `RTHS_OFS_CTRL, 32'h6);
        @(posedge clk) coast <= 1'b1;
        homing(2'h2, 8'h19, 1'b1);
        @(posedge clk) coast <= 1'b0;
        bus(1'b0, `RTHS_OFS_IRQ_STAT, 32'h3);
        bus(1'b1, `RTHS_OFS_PUSH_BACK, 32'h6);
        bus(1'b1, `RTHS_OFS_CTRL, 32'h7);
        homing(2'h2, 8'h22, 1'b0);
        // Two-sensor finishing on the encoder zero pulse
        bus(1'b1, `RTHS_OFS_CTRL, 32'h24);
        homing(2'h1, 8'h16, 1'b0);
        conclude;
    end
    // Hang guard, well past the few thousand cycles the runs need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        conclude;
    end
    // Verdict
    task conclude;
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
endmodule // return_to_home_sequencer_tb_top
